// *** sci_spi_cfg.sv ***
//==============================================================================
// sci_spi_cfg.sv
//==============================================================================
// Purpose: serial slave holding interface configuration and identity bytes
// Assumes: frame header of 16 bits, MSB first: read flag, 7 spare, address
// Notes:   engine runs on the serial clock; settings cross to mclk by
//          two-flop synchronisers
`include "sci_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module sci_spi_cfg
    import sci_pkg::*;
#(
    // identity codes; values are arbitrary
    parameter logic [7:0]  TYPE_CODE  = 8'h5a,
    parameter logic [15:0] IDENT_CODE = 16'h1234,
    parameter logic [7:0]  VER_CODE   = 8'h01,
    parameter logic [15:0] MAKER_CODE = 16'h0abc
)
(
    // system clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // serial link
    input  wire logic sclk,
    input  wire logic csN,
    input  wire logic dataIn,
    output var  logic dataOut,
    output var  logic dataOe,
    output var  logic miso,
    // settings seen in the mclk domain
    output var  logic cfgBitOrder,
    output var  logic cfgAscend,
    output var  logic cfgFourWire,
    output var  logic cfgEdgePol
);

    //==========================================================================
    // declarations
    //==========================================================================
    logic        frameRst;             // idle select or system reset
    sci_phase_t  phase_ff;             // frame phase
    sci_phase_t  nxt_phase;
    logic [3:0]  cnt_ff;               // bit count inside header or byte
    logic [3:0]  nxt_cnt;
    logic [14:0] hdr_ff;               // header shift
    logic [14:0] nxt_hdr;
    logic [7:0]  addr_ff;              // current register address
    logic [7:0]  nxt_addr;
    logic [6:0]  rx_ff;                // write data shift
    logic [6:0]  nxt_rx;
    logic [7:0]  tx_ff;                // read data shift, bit 7 on the pin
    logic [7:0]  nxt_tx;
    logic        order_ff;             // 1: least significant bit first
    logic        nxt_order;
    logic        ascend_ff;            // 1: streaming address counts up
    logic        nxt_ascend;
    logic        fourW_ff;             // 1: separate MISO output
    logic        nxt_fourW;
    logic        edgePol_ff;           // 1: launch on rising edge
    logic        nxt_edgePol;
    logic        idValid_ff;           // set once reset has released
    logic        reloadReq;            // soft reload strobe
    logic        storeWe;              // general register write
    logic [7:0]  storeAddr;
    logic [7:0]  storeData;
    logic [7:0]  store_ff [`SCI_STORE_DEPTH];  // registers 0x02 .. 0xa7
    logic        negBit_ff;            // falling edge copy of the bit
    logic        negRd_ff;             // falling edge copy of read phase
    logic        rdActive;             // read data on the pins
    logic        outBit;               // read data bit on the pins
    logic [3:0]  cfgVec;               // settings leaving the link domain
    logic [3:0]  sync1_ff;             // first synchroniser stage
    logic [3:0]  sync2_ff;             // second synchroniser stage

    //==========================================================================
    // helpers
    //==========================================================================
    // reverse a byte for least significant bit first transfers
    function automatic logic [7:0] bitSwap(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

    // read-only identity addresses
    function automatic logic isIdent(input logic [7:0] a);
        return (a == `SCI_ADDR_TYPE) || (a == `SCI_ADDR_IDLO) ||
               (a == `SCI_ADDR_IDHI) || (a == `SCI_ADDR_VER)  ||
               (a == `SCI_ADDR_MKLO) || (a == `SCI_ADDR_MKHI);
    endfunction

    // addresses held in the general store
    function automatic logic inStore(input logic [7:0] a);
        return (a >= `SCI_RELOAD_LO) && (a <= `SCI_RELOAD_HI) && !isIdent(a);
    endfunction

    // read value of any address
    function automatic logic [7:0] readByte(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            `SCI_ADDR_IFCFG:
            begin
                r[`SCI_BIT_ORDER]      = order_ff;
                r[7 - `SCI_BIT_ORDER]  = order_ff;
                r[`SCI_BIT_ASCEND]     = ascend_ff;
                r[7 - `SCI_BIT_ASCEND] = ascend_ff;
                r[`SCI_BIT_FOURW]      = fourW_ff;
                r[7 - `SCI_BIT_FOURW]  = fourW_ff;
            end
            `SCI_ADDR_EDGE: r[`SCI_BIT_EDGE] = edgePol_ff;
            // identity reads as zero until reset has released
            `SCI_ADDR_TYPE: r = idValid_ff ? TYPE_CODE : 8'h00;
            `SCI_ADDR_IDLO: r = idValid_ff ? IDENT_CODE[7:0] : 8'h00;
            `SCI_ADDR_IDHI: r = idValid_ff ? IDENT_CODE[15:8] : 8'h00;
            `SCI_ADDR_VER:  r = idValid_ff ? VER_CODE : 8'h00;
            `SCI_ADDR_MKLO: r = idValid_ff ? MAKER_CODE[7:0] : 8'h00;
            `SCI_ADDR_MKHI: r = idValid_ff ? MAKER_CODE[15:8] : 8'h00;
            default:
            begin
                if (inStore(a))
                begin
                    r = store_ff[a];
                end
            end
        endcase
        return r;
    endfunction

    // next streaming address
    function automatic logic [7:0] stepAddr(input logic [7:0] a,
                                            input logic       up);
        return up ? 8'(a + 8'h01) : 8'(a - 8'h01);
    endfunction

    // frame logic idles whenever select is high
    assign frameRst = sys_rst | csN;

    //==========================================================================
    // serial engine: next values
    //==========================================================================
    always_comb
    begin
        logic [7:0] wByte;
        wByte       = 8'h00;
        nxt_phase   = phase_ff;
        nxt_cnt     = 4'(cnt_ff + 4'h1);
        nxt_hdr     = hdr_ff;
        nxt_addr    = addr_ff;
        nxt_rx      = rx_ff;
        nxt_tx      = tx_ff;
        nxt_order   = order_ff;
        nxt_ascend  = ascend_ff;
        nxt_fourW   = fourW_ff;
        nxt_edgePol = edgePol_ff;
        reloadReq   = 1'b0;
        storeWe     = 1'b0;
        storeAddr   = addr_ff;
        storeData   = 8'h00;
        case (phase_ff)
            // header: read flag then address
            SCI_PH_HDR:
            begin
                nxt_hdr = {hdr_ff[13:0], dataIn};
                if (cnt_ff == `SCI_HDR_LAST)
                begin
                    nxt_cnt  = 4'h0;
                    nxt_addr = {hdr_ff[6:0], dataIn};
                    if (hdr_ff[`SCI_HDR_RW])
                    begin
                        nxt_phase = SCI_PH_RD;
                        nxt_tx    = readByte({hdr_ff[6:0], dataIn});
                        if (order_ff)
                        begin
                            nxt_tx = bitSwap(nxt_tx);
                        end
                    end
                    else
                    begin
                        nxt_phase = SCI_PH_WR;
                    end
                end
            end
            // write data byte
            SCI_PH_WR:
            begin
                nxt_rx = {rx_ff[5:0], dataIn};
                if (cnt_ff == `SCI_BYTE_LAST)
                begin
                    nxt_cnt  = 4'h0;
                    wByte    = order_ff ? bitSwap({rx_ff, dataIn})
                                        : {rx_ff, dataIn};
                    nxt_addr = stepAddr(addr_ff, ascend_ff);
                    storeData = wByte;
                    if (addr_ff == `SCI_ADDR_IFCFG)
                    begin
                        // a pair that disagrees keeps the old setting
                        if (wByte[`SCI_BIT_ORDER] ==
                            wByte[7 - `SCI_BIT_ORDER])
                        begin
                            nxt_order = wByte[`SCI_BIT_ORDER];
                        end
                        if (wByte[`SCI_BIT_ASCEND] ==
                            wByte[7 - `SCI_BIT_ASCEND])
                        begin
                            nxt_ascend = wByte[`SCI_BIT_ASCEND];
                        end
                        if (wByte[`SCI_BIT_FOURW] ==
                            wByte[7 - `SCI_BIT_FOURW])
                        begin
                            nxt_fourW = wByte[`SCI_BIT_FOURW];
                        end
                        // reload needs both copies; never stored
                        reloadReq = wByte[`SCI_BIT_RELOAD] &
                                    wByte[7 - `SCI_BIT_RELOAD];
                    end
                    else if (addr_ff == `SCI_ADDR_EDGE)
                    begin
                        nxt_edgePol = wByte[`SCI_BIT_EDGE];
                    end
                    else
                    begin
                        // identity and out of range writes are dropped
                        storeWe = inStore(addr_ff);
                    end
                end
            end
            // read data byte
            SCI_PH_RD:
            begin
                nxt_tx = {tx_ff[6:0], 1'b0};
                if (cnt_ff == `SCI_BYTE_LAST)
                begin
                    nxt_cnt  = 4'h0;
                    nxt_addr = stepAddr(addr_ff, ascend_ff);
                    nxt_tx   = readByte(stepAddr(addr_ff, ascend_ff));
                    if (order_ff)
                    begin
                        nxt_tx = bitSwap(nxt_tx);
                    end
                end
            end
            default:
            begin
                nxt_phase = SCI_PH_HDR;
                nxt_cnt   = 4'h0;
            end
        endcase
    end

    //==========================================================================
    // serial engine: frame state, cleared while select is high
    //==========================================================================
    always_ff @(posedge sclk or posedge frameRst)
    begin
        if (frameRst)
        begin
            phase_ff <= SCI_PH_HDR;
            cnt_ff   <= 4'h0;
            hdr_ff   <= 15'h0000;
            addr_ff  <= 8'h00;
            rx_ff    <= 7'h00;
            tx_ff    <= 8'h00;
        end
        else
        begin
            phase_ff <= nxt_phase;
            cnt_ff   <= nxt_cnt;
            hdr_ff   <= nxt_hdr;
            addr_ff  <= nxt_addr;
            rx_ff    <= nxt_rx;
            tx_ff    <= nxt_tx;
        end
    end

    //==========================================================================
    // interface settings: survive soft reload
    //==========================================================================
    always_ff @(posedge sclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            order_ff   <= `SCI_RST_ORDER;
            ascend_ff  <= `SCI_RST_ASCEND;
            fourW_ff   <= `SCI_RST_FOURW;
            edgePol_ff <= `SCI_RST_EDGE;
            idValid_ff <= 1'b0;
        end
        else
        begin
            order_ff   <= nxt_order;
            ascend_ff  <= nxt_ascend;
            fourW_ff   <= nxt_fourW;
            edgePol_ff <= nxt_edgePol;
            idValid_ff <= 1'b1;
        end
    end

    //==========================================================================
    // general store 0x02 .. 0xa7: reload restores defaults
    //==========================================================================
    always_ff @(posedge sclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `SCI_STORE_DEPTH; i++)
            begin
                store_ff[i] <= `SCI_RST_STORE;
            end
        end
        else if (reloadReq)
        begin
            // request is never stored, so it reads back as zero
            for (int i = 0; i < `SCI_STORE_DEPTH; i++)
            begin
                store_ff[i] <= `SCI_RST_STORE;
            end
        end
        else if (storeWe)
        begin
            store_ff[storeAddr] <= storeData;
        end
    end

    //==========================================================================
    // falling edge launch copies
    //==========================================================================
    always_ff @(negedge sclk or posedge frameRst)
    begin
        if (frameRst)
        begin
            negBit_ff <= 1'b0;
            negRd_ff  <= 1'b0;
        end
        else
        begin
            negBit_ff <= tx_ff[7];
            negRd_ff  <= (phase_ff == SCI_PH_RD);
        end
    end

    //==========================================================================
    // pin drive
    //==========================================================================
    // polarity picks the launching edge
    assign outBit   = edgePol_ff ? tx_ff[7] : negBit_ff;
    assign rdActive = edgePol_ff ? (phase_ff == SCI_PH_RD)
                                 : negRd_ff;
    // three-wire turns the data pin round; four-wire uses MISO
    assign dataOut  = outBit;
    assign dataOe   = rdActive & ~fourW_ff;
    assign miso     = rdActive & fourW_ff & outBit;

    //==========================================================================
    // settings into the mclk domain
    //==========================================================================
    assign cfgVec = {order_ff, ascend_ff, fourW_ff, edgePol_ff};

    // two flops per setting level
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sync
            always_ff @(posedge mclk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                end
                else
                begin
                    sync1_ff[g] <= cfgVec[g];
                    sync2_ff[g] <= sync1_ff[g];
                end
            end
        end
    endgenerate

    assign cfgBitOrder = sync2_ff[3];
    assign cfgAscend   = sync2_ff[2];
    assign cfgFourWire = sync2_ff[1];
    assign cfgEdgePol  = sync2_ff[0];

endmodule // sci_spi_cfg

`default_nettype wire

// *** sci_cfg.svh ***
//==============================================================================
// sci_cfg.svh
//==============================================================================
// Purpose: offsets, field positions, reset values and frame counts of the
//          serial configuration interface block
// Assumes: byte-wide registers addressed by an 8-bit register address
// Notes:   definitions only; included by its bare name
`ifndef SCI_CFG_SVH
`define SCI_CFG_SVH

//==============================================================================
// register offsets
//==============================================================================
`define SCI_ADDR_IFCFG   8'h00
`define SCI_ADDR_EDGE    8'h01
`define SCI_ADDR_TYPE    8'h03
`define SCI_ADDR_IDLO    8'h04
`define SCI_ADDR_IDHI    8'h05
`define SCI_ADDR_VER     8'h06
`define SCI_ADDR_MKLO    8'h0c
`define SCI_ADDR_MKHI    8'h0d
`define SCI_RELOAD_LO    8'h02
`define SCI_RELOAD_HI    8'ha7
`define SCI_STORE_DEPTH  168

//==============================================================================
// field positions in interface_config (mirror sits at 7 - position); edge bit sits alone in its own register
//==============================================================================
`define SCI_BIT_RELOAD   7
`define SCI_BIT_ORDER    6
`define SCI_BIT_ASCEND   5
`define SCI_BIT_FOURW    4
`define SCI_BIT_EDGE     0

//==============================================================================
// reset values
//==============================================================================
`define SCI_RST_ORDER    1'h0
`define SCI_RST_ASCEND   1'h1
`define SCI_RST_FOURW    1'h0
`define SCI_RST_EDGE     1'h0
`define SCI_RST_STORE    8'h00

//==============================================================================
// frame counts
//==============================================================================
`define SCI_HDR_LAST     4'hf
`define SCI_BYTE_LAST    4'h7
`define SCI_HDR_RW       14

`endif

// *** sci_pkg.sv ***
//==============================================================================
// sci_pkg.sv
//==============================================================================
// Purpose: types of the serial configuration interface block
// Assumes: nothing
// Notes:   constants live in sci_cfg.svh
`default_nettype none

package sci_pkg;

    //==========================================================================
    // frame phase of the serial engine
    //==========================================================================
    typedef enum logic [1:0] {
        SCI_PH_HDR = 2'b00,  // instruction and address bits
        SCI_PH_WR  = 2'b01,  // write data bytes
        SCI_PH_RD  = 2'b10   // read data bytes
    } sci_phase_t;

endpackage

`default_nettype wire

// *** sci_spi_cfg_checker.sv ***
//==============================================================================
// Purpose: concurrent checks on the ports of the configuration slave
// Assumes: settings reach mclk 2-3 edges after the serial edge
// Notes:   bound to every sci_spi_cfg instance
`timescale 1ns/10ps
`default_nettype none

module sci_spi_cfg_checker
(
    // system
    input  wire logic mclk,
    input  wire logic sys_rst,
    // link and settings
    input  wire logic sclk,
    input  wire logic csN,
    input  wire logic dataIn,
    input  wire logic dataOut,
    input  wire logic dataOe,
    input  wire logic miso,
    input  wire logic cfgBitOrder,
    input  wire logic cfgAscend,
    input  wire logic cfgFourWire,
    input  wire logic cfgEdgePol
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    //==========================================================================
    // pin use per wire mode
    //==========================================================================
    chk_miso_three_wire: assert property (miso |-> cfgFourWire)
        else $error("miso active in three-wire mode");
    chk_oe_four_wire: assert property (dataOe |-> !cfgFourWire)
        else $error("data pin driven in four-wire mode");
    chk_idle_outputs: assert property (csN |-> !dataOe && !miso)
        else $error("read output active without chip select");
    chk_oe_held_frame: assert property (dataOe && !csN ##1 !csN |-> dataOe)
        else $error("data pin released inside a read frame");

    //==========================================================================
    // settings after reset and between frames
    //==========================================================================
    chk_ascend_default: assert property ($fell(sys_rst) |-> ##[0:4] cfgAscend)
        else $error("ascend setting not set after reset");
    chk_zero_defaults: assert property ($fell(sys_rst) |->
        (!cfgBitOrder && !cfgFourWire && !cfgEdgePol) [*4])
        else $error("order, mode or polarity not zero after reset");
    chk_cfg_quiet_idle: assert property (csN [*8] |-> $stable(cfgBitOrder)
        && $stable(cfgAscend) && $stable(cfgFourWire))
        else $error("setting changed with no frame");
    chk_pol_quiet_idle: assert property (csN [*8] |-> $stable(cfgEdgePol))
        else $error("polarity changed with no frame");

    // main scenarios
    cover property ($rose(dataOe));
    cover property ($rose(miso));
    cover property ($rose(cfgEdgePol));
    cover property ($rose(cfgBitOrder));
endmodule // sci_spi_cfg_checker

bind sci_spi_cfg sci_spi_cfg_checker chk (.mclk(mclk), .sys_rst(sys_rst),
    .sclk(sclk), .csN(csN), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .miso(miso), .cfgBitOrder(cfgBitOrder),
    .cfgAscend(cfgAscend), .cfgFourWire(cfgFourWire), .cfgEdgePol(cfgEdgePol));

`default_nettype wire

// *** sci_spi_master.sv ***
//==============================================================================
// Purpose: serial master model for the configuration slave
// Assumes: sclk idles low, runs inside frames and pulses once during reset, 48 ns period
// Notes:   a released data pin shows the inverse of the last driven bit
`timescale 1ns/10ps
`default_nettype none

module sci_spi_master
(
    // serial link
    output var  logic sclk,
    output var  logic csN,
    output wire logic dataIn,
    input  wire logic dataOut,
    input  wire logic dataOe,
    input  wire logic miso
);
    logic drv;     // master drives the data pin
    logic mv;      // last value put on the data pin
    logic pinVal;  // resolved data pin level
    int   edgeErr; // read bits seen moving on the wrong edge

    // device wins while enabled; released pin flips away from last value
    assign pinVal = dataOe ? dataOut : (drv ? mv : ~mv);
    assign dataIn = pinVal;

    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        drv = 1'b0;
        mv = 1'b0;
        edgeErr = 0;
        // one pulse while the bench holds reset
        #2;
        sclk = 1'b1;
        #2;
        sclk = 1'b0;
    end

    // position of data bit k inside the packed bytes
    function automatic int bp(input int k, input logic lsb);
        return (k / 8) * 8 + (lsb ? k % 8 : 7 - k % 8);
    endfunction

    //==========================================================================
    // one frame: header, then n bytes written or read
    //==========================================================================
    task automatic xfer(input logic rd, input logic [7:0] addr, input int n,
        input logic lsb, input logic pol, input logic fw,
        input logic [31:0] wd, output logic [31:0] rdv);
        logic [15:0] hdr;
        logic        s;
        int          c;
        int          last;
        hdr = {rd, 7'h00, addr};
        rdv = 32'h0;
        last = 16 + 8 * n;
        csN = 1'b0;
        #24;
        for (c = 1; c <= last; c++)
        begin
            // drive header or write bits just after the falling edge
            if (c <= 16 || !rd)
            begin
                drv = 1'b1;
                mv = (c <= 16) ? hdr[16 - c] : wd[bp(c - 17, lsb)];
            end
            else
                drv = 1'b0;
            #24;
            s = fw ? miso : pinVal;
            // polarity 0 takes on rising, polarity 1 checks it held
            if (rd && c >= 17 && !pol)
                rdv[bp(c - 17, lsb)] = s;
            else if (rd && c >= 17 && rdv[bp(c - 17, lsb)] !== s)
                edgeErr++;
            sclk = 1'b1;
            #24;
            s = fw ? miso : pinVal;
            // polarity 1 takes on falling, polarity 0 checks it held
            if (rd && pol && c >= 16 && c < last)
                rdv[bp(c - 16, lsb)] = s;
            else if (rd && !pol && c >= 17 && rdv[bp(c - 17, lsb)] !== s)
                edgeErr++;
            sclk = 1'b0;
        end
        #24;
        drv = 1'b0;
        csN = 1'b1;
        #24;
    endtask
endmodule // sci_spi_master

`default_nettype wire

// *** spi_config_interface_control_bench.sv ***
//==============================================================================
// Purpose: self-checking bench of the serial configuration slave
// Assumes: frames come from the master model with modes tracked here
// Notes:   identity codes are arbitrary values
`include "sci_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module spi_config_interface_control_bench;
    localparam logic [7:0]  TY = 8'h3c;    // arbitrary
    localparam logic [15:0] ID = 16'h9e71; // arbitrary
    localparam logic [7:0]  VE = 8'h27;    // arbitrary
    localparam logic [15:0] MK = 16'h5bd2; // arbitrary
    logic mclk, sys_rst, sclk, csN, dataIn, dataOut, dataOe, miso;
    logic cBo, cAs, cFw, cEp;  // settings seen at mclk
    logic lsb, pol, fw;        // modes the bench expects
    logic [31:0] v;            // last read value
    int   err_count, tests_run;

    sci_spi_cfg #(.TYPE_CODE(TY), .IDENT_CODE(ID), .VER_CODE(VE),
        .MAKER_CODE(MK)) dut (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
        .csN(csN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .miso(miso), .cfgBitOrder(cBo), .cfgAscend(cAs), .cfgFourWire(cFw),
        .cfgEdgePol(cEp));
    sci_spi_master m (.sclk(sclk), .csN(csN), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .miso(miso));

    always #4 mclk = ~mclk;

    //==========================================================================
    // shared tasks
    //==========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
        logic [31:0] x;
        m.xfer(1'b0, a, n, lsb, pol, fw, {16'h0, d}, x);
    endtask
    task automatic rdn(input logic [7:0] a, input int n);
        m.xfer(1'b1, a, n, lsb, pol, fw, 32'h0, v);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    //==========================================================================
    // scenarios
    //==========================================================================
    task automatic t_defaults();
        check({28'h0, cBo, cAs, cFw, cEp}, 32'h4);
        rdn(`SCI_ADDR_IFCFG, 2);
        check(v, 32'h0024);
    endtask
    task automatic t_ident();
        rdn(`SCI_ADDR_TYPE, 4);
        check(v, {VE, ID, TY});
        rdn(`SCI_ADDR_MKLO, 2);
        check(v, {16'h0, MK});
        wr(`SCI_ADDR_IDLO, 16'hff, 1);
        wr(8'ha8, 16'h77, 1);
        rdn(`SCI_ADDR_IDLO, 1);
        check(v, {24'h0, ID[7:0]});
        rdn(8'ha8, 1);
        check(v, 32'h0);
    endtask
    task automatic t_descend();
        wr(`SCI_ADDR_IFCFG, 16'h00, 1);
        check({31'h0, cAs}, 32'h0);
        wr(8'h11, 16'hb2c3, 2);
        rdn(8'h11, 2);
        check(v, 32'hb2c3);
        wr(`SCI_ADDR_IFCFG, 16'h24, 1);
        rdn(8'h10, 2);
        check(v, 32'hc3b2);
    endtask
    task automatic t_lsb();
        wr(`SCI_ADDR_IFCFG, 16'h66, 1);
        lsb = 1'b1;
        check({31'h0, cBo}, 32'h1);
        wr(8'h20, 16'h1e, 1);
        rdn(8'h20, 1);
        check(v, 32'h1e);
        wr(`SCI_ADDR_IFCFG, 16'h24, 1);
        lsb = 1'b0;
        rdn(8'h20, 1);
        check(v, 32'h1e);
    endtask
    task automatic t_mismatch();
        wr(`SCI_ADDR_IFCFG, 16'h74, 1);
        rdn(`SCI_ADDR_IFCFG, 1);
        check(v, 32'h24);
        check({30'h0, cBo, cFw}, 32'h0);
    endtask
    task automatic t_reload();
        wr(8'h30, 16'ha5, 1);
        wr(8'ha7, 16'h5a, 1);
        wr(`SCI_ADDR_EDGE, 16'h01, 1);
        pol = 1'b1;
        check({31'h0, cEp}, 32'h1);
        wr(`SCI_ADDR_IFCFG, 16'ha4, 1);
        rdn(8'h30, 1);
        check(v, 32'ha5);
        wr(`SCI_ADDR_IFCFG, 16'ha5, 1);
        rdn(8'h30, 1);
        check(v, 32'h0);
        rdn(8'ha7, 1);
        check(v, 32'h0);
        rdn(`SCI_ADDR_IFCFG, 2);
        check(v, 32'h0124);
        rdn(`SCI_ADDR_TYPE, 4);
        check(v, {VE, ID, TY});
        wr(`SCI_ADDR_EDGE, 16'h00, 1);
        pol = 1'b0;
    endtask
    task automatic t_four_wire();
        wr(`SCI_ADDR_IFCFG, 16'h3c, 1);
        fw = 1'b1;
        check({31'h0, cFw}, 32'h1);
        rdn(`SCI_ADDR_IDHI, 1);
        check(v, {24'h0, ID[15:8]});
        wr(`SCI_ADDR_IFCFG, 16'h24, 1);
        fw = 1'b0;
        rdn(`SCI_ADDR_IDHI, 1);
        check(v, {24'h0, ID[15:8]});
    endtask

    //==========================================================================
    // main sequence and hang guard
    //==========================================================================
    initial
    begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        {lsb, pol, fw} = 3'b000;
        err_count = 0;
        tests_run = 0;
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        #13;
        t_defaults();
        t_ident();
        t_descend();
        t_lsb();
        t_mismatch();
        t_reload();
        t_four_wire();
        check(32'(m.edgeErr), 32'h0);
        close_out();
    end
    initial
    begin
        #500000;
        err_count++;
        close_out();
    end
endmodule // spi_config_interface_control_bench

`default_nettype wire
